// file: aadf_map.vh
// register map, field positions, reset values and ratios of the aux decimation filter
`ifndef AADF_MAP_VH
`define AADF_MAP_VH
// ****************************************
// register word indices (byte address is the index times four)
// ****************************************
`define AADF_IDX_INPUT_SEL   8'h16
`define AADF_IDX_GAIN_RATE   8'h17
`define AADF_IDX_OFFSET      8'h18
`define AADF_IDX_FSCALE      8'h19
`define AADF_IDX_CMD         8'h1A
`define AADF_IDX_STATUS      8'h1B
`define AADF_IDX_DATA        8'h1C
`define AADF_ADDR_W          10
// ****************************************
// fields
// ****************************************
`define AADF_POS_SEL_LSB     4
`define AADF_NEG_SEL_LSB     0
`define AADF_GAIN_LSB        5
`define AADF_REF_LSB         2
`define AADF_RATE_LSB        0
// ****************************************
// reset values
// ****************************************
`define AADF_INPUT_SEL_RST   8'h00
`define AADF_GAIN_RATE_RST   8'h00
`define AADF_OFFSET_RST      16'h0000
`define AADF_FSCALE_RST      16'h8000
// ****************************************
// commands
// ****************************************
`define AADF_CMD_BEGIN       7'h06
`define AADF_CMD_HALT        7'h07
// ****************************************
// rates and timing
// ****************************************
`define AADF_RATE_10         2'h0
`define AADF_RATE_100        2'h1
`define AADF_RATE_400        2'h2
`define AADF_RATE_800        2'h3
`define AADF_MOD_DIV         144
`define AADF_SINC1_RATIO     10
`define AADF_GAIN_BYPASS_MAX 3'h2
`endif

// file: aadf_sinc3.v
// third-order sinc decimator for a one-bit stream
`timescale 1ns/10ps
`include "aadf_map.vh"
module aadf_sinc3 #(
  parameter W = 30
) (
  input  wire         clk_i,
  input  wire         rst_i,
  input  wire         clear_i,
  input  wire         bit_i,
  input  wire         bit_valid_i,
  input  wire [1:0]   rate_i,
  output reg  [W-1:0] out_o,
  output reg          out_valid_o
);
  reg [W-1:0] acc1;
  reg [W-1:0] acc2;
  reg [W-1:0] acc3;
  reg [W-1:0] d1;
  reg [W-1:0] d2;
  reg [W-1:0] d3;
  reg [9:0]   cnt;
  reg [1:0]   warm;
  wire [W-1:0] c1 = acc3 - d1;
  wire [W-1:0] c2 = c1 - d2;
  wire [W-1:0] c3 = c2 - d3;

  function [9:0] ratio_last;
    input [1:0] r;
    begin
      case (r)
        `AADF_RATE_800: ratio_last = 10'd63;
        `AADF_RATE_400: ratio_last = 10'd127;
        default:        ratio_last = 10'd511;
      endcase
    end
  endfunction

  always @(posedge clk_i) begin
    out_valid_o <= 1'b0;
    if (rst_i || clear_i) begin
      acc1 <= {W{1'b0}};
      acc2 <= {W{1'b0}};
      acc3 <= {W{1'b0}};
      d1 <= {W{1'b0}};
      d2 <= {W{1'b0}};
      d3 <= {W{1'b0}};
      cnt <= 10'h000;
      warm <= 2'h0;
      out_o <= {W{1'b0}};
    end else if (bit_valid_i) begin
      acc1 <= acc1 + {{(W-1){1'b0}}, bit_i};
      acc2 <= acc2 + acc1;
      acc3 <= acc3 + acc2;
      if (cnt == ratio_last(rate_i)) begin
        cnt <= 10'h000;
        d1 <= acc3;
        d2 <= c1;
        d3 <= c2;
        out_o <= c3;
        // first two outputs are unsettled, hold them back
        if (warm == 2'h2)
          out_valid_o <= 1'b1;
        else
          warm <= warm + 2'h1;
      end else begin
        cnt <= cnt + 10'h001;
      end
    end
  end
endmodule // aadf_sinc3

// file: aadf_calib.v
// offset and full-scale correction of a 24-bit result
`timescale 1ns/10ps
module aadf_calib (
  input  wire        clk_i,
  input  wire        rst_i,
  input  wire [23:0] raw_i,
  input  wire        raw_valid_i,
  input  wire [15:0] offset_i,
  input  wire [15:0] fscale_i,
  output reg  [23:0] cal_o,
  output reg         cal_valid_o
);
  wire signed [24:0] diff = $signed({raw_i[23], raw_i}) - $signed({{9{offset_i[15]}}, offset_i});
  wire signed [41:0] prod = diff * $signed({1'b0, fscale_i});
  wire signed [26:0] scaled = prod[41:15];

  always @(posedge clk_i) begin
    if (rst_i) begin
      cal_o <= 24'h000000;
      cal_valid_o <= 1'b0;
    end else begin
      cal_valid_o <= raw_valid_i;
      if (raw_valid_i) begin
        // saturate instead of wrapping on overrange
        if (scaled > $signed(27'h07FFFFF))
          cal_o <= 24'h7FFFFF;
        else if (scaled < $signed(27'h7800000))
          cal_o <= 24'h800000;
        else
          cal_o <= scaled[23:0];
      end
    end
  end
endmodule // aadf_calib

// file: aadf_top.v
// aux converter control, modulator timing, decimation and register slave
//
// The Wishbone interface to the registers is this design's own decision.
`timescale 1ns/10ps
`include "aadf_map.vh"
module aadf_top #(
  parameter MOD_DIV = `AADF_MOD_DIV
) (
  input  wire        clk_i,
  input  wire        rst_i,
  input  wire [31:0] wb_adr_i,
  input  wire [31:0] wb_dat_i,
  output reg  [31:0] wb_dat_o,
  input  wire [3:0]  wb_sel_i,
  input  wire        wb_we_i,
  input  wire        wb_cyc_i,
  input  wire        wb_stb_i,
  output reg         wb_ack_o,
  output wire        wb_err_o,
  input  wire        mod_bit_i,
  output reg         mod_sample_o,
  output wire [3:0]  aux_pos_input_sel_o,
  output wire [3:0]  aux_neg_input_sel_o,
  output wire [2:0]  aux_gain_code_o,
  output wire [7:0]  amp_gain_o,
  output wire [2:0]  mod_gain_o,
  output wire        amp_bypass_o,
  output reg  [4:0]  ref_sel_onehot_o,
  output wire        running_o,
  output wire [23:0] result_o,
  output wire        result_valid_o
);
  // ****************************************
  // registers
  // ****************************************
  reg  [7:0]  aux_input_select;
  reg  [7:0]  aux_gain_rate_config;
  reg  [15:0] offset_corr;
  reg  [15:0] fscale_corr;
  reg         running;
  reg         restart;
  reg         fresh;
  // config byte: gain [7:5], reference [4:2], rate [1:0], no bit shared
  wire [1:0]  aux_rate_code = aux_gain_rate_config[`AADF_RATE_LSB +: 2];
  wire [2:0]  aux_ref_code  = aux_gain_rate_config[`AADF_REF_LSB +: 3];
  wire [7:0]  reg_index     = wb_adr_i[9:2];
  wire        wb_req        = wb_cyc_i && wb_stb_i && !wb_ack_o;
  wire        wb_hit        = (reg_index >= `AADF_IDX_INPUT_SEL) &&
                              (reg_index <= `AADF_IDX_DATA) && (wb_adr_i[31:10] == 22'h000000);

  // ****************************************
  // field decode
  // ****************************************
  assign aux_pos_input_sel_o = aux_input_select[`AADF_POS_SEL_LSB +: 4];
  assign aux_neg_input_sel_o = aux_input_select[`AADF_NEG_SEL_LSB +: 4];
  assign aux_gain_code_o     = aux_gain_rate_config[`AADF_GAIN_LSB +: 3];
  assign amp_bypass_o        = aux_gain_code_o <= `AADF_GAIN_BYPASS_MAX;
  // gain split: modulator carries up to 4, the amplifier the rest
  assign mod_gain_o = amp_bypass_o ? (3'h1 << aux_gain_code_o) : 3'h4;
  assign amp_gain_o = amp_bypass_o ? 8'h01 : (8'h01 << (aux_gain_code_o - 3'h2));
  assign running_o  = running;
  // refused requests never see ack, so a master gets one answer or the other
  assign wb_err_o   = wb_cyc_i && wb_stb_i && !wb_hit && !wb_ack_o;

  always @* begin
    // five sources in three bits; codes 5 to 7 fall back to the supply
    case (aux_ref_code)
      3'h0:    ref_sel_onehot_o = 5'h01;
      3'h1:    ref_sel_onehot_o = 5'h02;
      3'h2:    ref_sel_onehot_o = 5'h04;
      3'h3:    ref_sel_onehot_o = 5'h08;
      default: ref_sel_onehot_o = 5'h10;
    endcase
  end

  // ****************************************
  // command decode
  // ****************************************
  // the command register takes the opcode byte; a serial front end acts on bit 7 of 8
  // so the low bit is a don't-care, as with 0Ch/0Dh and 0Eh/0Fh
  wire       cmd_wr   = wb_req && wb_hit && wb_we_i && wb_sel_i[0] &&
                        (reg_index == `AADF_IDX_CMD);
  wire [6:0] cmd_op   = wb_dat_i[7:1];
  wire       cmd_beg  = cmd_wr && (cmd_op == `AADF_CMD_BEGIN);
  wire       cmd_halt = cmd_wr && (cmd_op == `AADF_CMD_HALT);
  wire       cfg_wr   = wb_req && wb_hit && wb_we_i && wb_sel_i[0] &&
                        ((reg_index == `AADF_IDX_INPUT_SEL) || (reg_index == `AADF_IDX_GAIN_RATE));

  // ****************************************
  // register bus
  // ****************************************
  always @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
      aux_input_select <= `AADF_INPUT_SEL_RST;
      aux_gain_rate_config <= `AADF_GAIN_RATE_RST;
      offset_corr <= `AADF_OFFSET_RST;
      fscale_corr <= `AADF_FSCALE_RST;
      running <= 1'b0;
      restart <= 1'b0;
    end else begin
      wb_ack_o <= wb_req && wb_hit;
      restart <= 1'b0;
      if (cmd_beg) begin
        running <= 1'b1;
        restart <= 1'b1;
      end else if (cmd_halt) begin
        running <= 1'b0;
      end
      // settings change mid-conversion restarts the filter
      if (cfg_wr)
        restart <= 1'b1;
      if (wb_req && wb_hit && wb_we_i) begin
        case (reg_index)
          `AADF_IDX_INPUT_SEL: if (wb_sel_i[0]) aux_input_select <= wb_dat_i[7:0];
          `AADF_IDX_GAIN_RATE: if (wb_sel_i[0]) aux_gain_rate_config <= wb_dat_i[7:0];
          `AADF_IDX_OFFSET: begin
            if (wb_sel_i[0]) offset_corr[7:0] <= wb_dat_i[7:0];
            if (wb_sel_i[1]) offset_corr[15:8] <= wb_dat_i[15:8];
          end
          `AADF_IDX_FSCALE: begin
            if (wb_sel_i[0]) fscale_corr[7:0] <= wb_dat_i[7:0];
            if (wb_sel_i[1]) fscale_corr[15:8] <= wb_dat_i[15:8];
          end
          default: ;
        endcase
      end
      if (wb_req && wb_hit && !wb_we_i) begin
        case (reg_index)
          `AADF_IDX_INPUT_SEL: wb_dat_o <= {24'h000000, aux_input_select};
          `AADF_IDX_GAIN_RATE: wb_dat_o <= {24'h000000, aux_gain_rate_config};
          `AADF_IDX_OFFSET:    wb_dat_o <= {16'h0000, offset_corr};
          `AADF_IDX_FSCALE:    wb_dat_o <= {16'h0000, fscale_corr};
          `AADF_IDX_STATUS:    wb_dat_o <= {30'h00000000, fresh, running};
          `AADF_IDX_DATA:      wb_dat_o <= {8'h00, result_o};
          default:             wb_dat_o <= 32'h00000000;
        endcase
      end
    end
  end

  // ****************************************
  // modulator timing
  // ****************************************
  reg  [7:0] mod_cnt;
  reg        bit_s1;
  reg        bit_s2;
  reg        bit_valid;
  // halted means held in clear, so every begin starts from empty integrators
  wire       clear = restart || !running;

  always @(posedge clk_i) begin
    if (rst_i) begin
      mod_cnt <= 8'h00;
      mod_sample_o <= 1'b0;
      bit_s1 <= 1'b0;
      bit_s2 <= 1'b0;
      bit_valid <= 1'b0;
    end else begin
      bit_s1 <= mod_bit_i;
      bit_s2 <= bit_s1;
      mod_sample_o <= 1'b0;
      bit_valid <= mod_sample_o;
      // sample tick every MOD_DIV device clocks, so all rates follow clk
      if (mod_cnt == MOD_DIV[7:0] - 8'h01) begin
        mod_cnt <= 8'h00;
        mod_sample_o <= 1'b1;
      end else begin
        mod_cnt <= mod_cnt + 8'h01;
      end
    end
  end

  // ****************************************
  // filter stages
  // ****************************************
  wire [29:0] s3_out;
  wire        s3_valid;

  // the stage holds back the first two outputs of every restart
  aadf_sinc3 #(
    .W(30)
  ) u_sinc3 (
    .clk_i       (clk_i),
    .rst_i       (rst_i),
    .clear_i     (clear),
    .bit_i       (bit_s2),
    .bit_valid_i (bit_valid && running),
    .rate_i      (aux_rate_code),
    .out_o       (s3_out),
    .out_valid_o (s3_valid)
  );

  // sinc3 gain is A cubed; map 0..A cubed onto a signed full scale
  // all ones lands one step past the top, so it clips instead of wrapping
  function [23:0] s3_scale;
    input [29:0] v;
    input [1:0]  r;
    reg   [24:0] u;
    begin
      case (r)
        `AADF_RATE_800: u = {v[18:0], 6'h00};
        `AADF_RATE_400: u = {v[21:0], 3'h0};
        default:        u = v[27:3];
      endcase
      if (u[24])
        s3_scale = 24'h7FFFFF;
      else
        s3_scale = u[23:0] ^ 24'h800000;
    end
  endfunction
  wire [23:0] s3_word = s3_scale(s3_out, aux_rate_code);

  // ****************************************
  // second stage
  // ****************************************
  reg [27:0] s1_acc;
  reg [3:0]  s1_cnt;
  reg [23:0] raw;
  reg        raw_valid;
  wire [27:0] s1_sum = s1_acc + {{4{s3_word[23]}}, s3_word};

  // divide by ten: multiply by 1677721/2^24
  // rounded down so ten bottom-code words cannot wrap past the most negative code
  function [23:0] div10;
    input [27:0] v;
    reg [52:0] p;
    begin
      p = $signed({{25{v[27]}}, v}) * $signed(53'd1677721);
      div10 = p[47:24];
    end
  endfunction

  always @(posedge clk_i) begin
    if (rst_i || clear) begin
      s1_acc <= 28'h0000000;
      s1_cnt <= 4'h0;
      raw <= 24'h000000;
      raw_valid <= 1'b0;
    end else begin
      raw_valid <= 1'b0;
      if (s3_valid) begin
        if (aux_rate_code != `AADF_RATE_10) begin
          raw <= s3_word;
          raw_valid <= 1'b1;
        end else if (s1_cnt == `AADF_SINC1_RATIO - 1) begin
          s1_cnt <= 4'h0;
          s1_acc <= 28'h0000000;
          raw <= div10(s1_sum);
          raw_valid <= 1'b1;
        end else begin
          s1_cnt <= s1_cnt + 4'h1;
          s1_acc <= s1_sum;
        end
      end
    end
  end

  // ****************************************
  // correction and status
  // ****************************************
  aadf_calib u_calib (
    .clk_i       (clk_i),
    .rst_i       (rst_i),
    .raw_i       (raw),
    .raw_valid_i (raw_valid),
    .offset_i    (offset_corr),
    .fscale_i    (fscale_corr),
    .cal_o       (result_o),
    .cal_valid_o (result_valid_o)
  );

  // fresh flag: set by a result, cleared by reading data; set wins
  wire data_rd = wb_req && wb_hit && !wb_we_i && (reg_index == `AADF_IDX_DATA);
  always @(posedge clk_i) begin
    if (rst_i)
      fresh <= 1'b0;
    else if (result_valid_o)
      fresh <= 1'b1;
    else if (data_rd)
      fresh <= 1'b0;
  end
endmodule // aadf_top

// file: aadf_mod_model.sv
// modulator bitstream model feeding the aux decimation filter
`timescale 1ns/10ps
module aadf_mod_model (
  input  wire clk_i,
  input  wire rst_i,
  input  wire sample_i,
  input  wire ones_i,
  output reg  bit_o
);
  // ****************
  // bitstream
  // ****************
  // constant density only: enough to tell full high from full low
  always @(posedge clk_i) begin
    if (rst_i) begin
      bit_o <= 1'b0;
    end else if (sample_i) begin
      bit_o <= ones_i;
    end
  end
endmodule // aadf_mod_model

// file: aadf_top_chk.sv
// assertions on the ports of the aux decimation filter
`timescale 1ns/10ps
module aadf_chk #(
  parameter MOD_DIV = 144
) (
  input wire        clk_i,
  input wire        rst_i,
  input wire        wb_ack_o,
  input wire        wb_err_o,
  input wire        mod_sample_o,
  input wire [2:0]  aux_gain_code_o,
  input wire [7:0]  amp_gain_o,
  input wire [2:0]  mod_gain_o,
  input wire        amp_bypass_o,
  input wire [4:0]  ref_sel_onehot_o,
  input wire        running_o,
  input wire [23:0] result_o,
  input wire        result_valid_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // ****************
  // gap counters
  // ****************
  reg [15:0] sc;
  reg [15:0] vc;
  reg        sseen;
  reg        vseen;
  always @(posedge clk_i) begin
    if (rst_i) begin
      sc    <= 16'h0;
      vc    <= 16'h0;
      sseen <= 1'b0;
      vseen <= 1'b0;
    end else begin
      sc    <= mod_sample_o ? 16'h0 : sc + 16'h1;
      vc    <= result_valid_o ? 16'h0 : (vc == 16'hFFFF ? vc : vc + 16'h1);
      sseen <= sseen | mod_sample_o;
      vseen <= vseen | result_valid_o;
    end
  end
  // ****************
  // properties
  // ****************
  property p_mod_gap;
    sseen |-> sc < MOD_DIV;
  endproperty
  a_mod_gap: assert property (p_mod_gap) else $error("sample gap too long");
  property p_bypass;
    amp_bypass_o == (aux_gain_code_o <= 3'h2);
  endproperty
  a_bypass: assert property (p_bypass) else $error("bypass mismatch");
  property p_mod_four;
    !amp_bypass_o |-> mod_gain_o == 3'h4;
  endproperty
  a_mod_four: assert property (p_mod_four) else $error("modulator gain");
  property p_gain_pow;
    ({3'h0, amp_gain_o} * {8'h0, mod_gain_o}) == (11'h1 << aux_gain_code_o);
  endproperty
  a_gain_pow: assert property (p_gain_pow) else $error("gain product");
  property p_ref_one;
    $onehot(ref_sel_onehot_o);
  endproperty
  a_ref_one: assert property (p_ref_one) else $error("reference select");
  property p_valid_pulse;
    result_valid_o |=> !result_valid_o;
  endproperty
  a_valid_pulse: assert property (p_valid_pulse) else $error("valid too long");
  property p_hold;
    !result_valid_o |-> $stable(result_o);
  endproperty
  a_hold: assert property (p_hold) else $error("result not held");
  property p_idle;
    !running_o [*3] |-> !result_valid_o;
  endproperty
  a_idle: assert property (p_idle) else $error("result while halted");
  property p_spacing;
    result_valid_o && vseen |-> vc >= 64 * MOD_DIV - 1;
  endproperty
  a_spacing: assert property (p_spacing) else $error("results too close");
  property p_err_ack;
    wb_err_o |=> !wb_ack_o;
  endproperty
  a_err_ack: assert property (p_err_ack) else $error("ack on refused access");
endmodule // aadf_chk
bind aadf_top aadf_chk #(.MOD_DIV(MOD_DIV)) u_chk (.clk_i(clk_i), .rst_i(rst_i),
  .wb_ack_o(wb_ack_o), .wb_err_o(wb_err_o), .mod_sample_o(mod_sample_o),
  .aux_gain_code_o(aux_gain_code_o), .amp_gain_o(amp_gain_o), .mod_gain_o(mod_gain_o),
  .amp_bypass_o(amp_bypass_o), .ref_sel_onehot_o(ref_sel_onehot_o),
  .running_o(running_o), .result_o(result_o), .result_valid_o(result_valid_o));

// file: tb.sv
// self-checking testbench of the aux decimation filter
`timescale 1ns/10ps
module tb;
  localparam MD = 8;
  reg         clk_i = 1'b0;
  reg         rst_i = 1'b1;
  reg  [31:0] wb_adr_i = 32'h0;
  reg  [31:0] wb_dat_i = 32'h0;
  reg         wb_we_i = 1'b0;
  reg         cyc = 1'b0;
  reg         ones = 1'b0;
  wire [31:0] wb_dat_o;
  wire        wb_ack_o, wb_err_o, mod_bit_i, mod_sample_o, amp_bypass_o;
  wire        running_o, result_valid_o;
  wire [3:0]  aux_pos_input_sel_o, aux_neg_input_sel_o;
  wire [2:0]  aux_gain_code_o, mod_gain_o;
  wire [7:0]  amp_gain_o;
  wire [4:0]  ref_sel_onehot_o;
  wire [23:0] result_o;
  integer     miscompares = 0;
  integer     compares = 0;
  integer     i;
  reg  [31:0] q;
  reg         er;
  aadf_top #(.MOD_DIV(MD)) u_dut (.clk_i, .rst_i, .wb_adr_i, .wb_dat_i, .wb_dat_o,
    .wb_sel_i(4'hF), .wb_we_i, .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_ack_o, .wb_err_o,
    .mod_bit_i, .mod_sample_o, .aux_pos_input_sel_o, .aux_neg_input_sel_o,
    .aux_gain_code_o, .amp_gain_o, .mod_gain_o, .amp_bypass_o, .ref_sel_onehot_o,
    .running_o, .result_o, .result_valid_o);
  aadf_mod_model u_mod (.clk_i, .rst_i, .sample_i(mod_sample_o), .ones_i(ones),
    .bit_o(mod_bit_i));
  // ****************
  // shared tasks
  // ****************
  task finish_test;
    begin
      $display("compares %0d miscompares %0d", compares, miscompares);
      if (miscompares == 0 && compares > 0) begin
        $display("Test passed");
      end else begin
        $display("Test failed");
      end
      $finish;
    end
  endtask
  task chk(input [31:0] g, input [31:0] e);
    begin
      compares = compares + 1;
      if (g !== e) begin
        miscompares = miscompares + 1;
        $display("wrong value at %0t: got %h expected %h", $time, g, e);
      end
    end
  endtask
  // one classic cycle; ends when ack or refusal is seen
  task wb(input [7:0] idx, input w, input [31:0] d);
    integer n;
    begin
      @(posedge clk_i);
      wb_adr_i <= {22'h0, idx, 2'h0};
      wb_we_i <= w;
      wb_dat_i <= d;
      cyc <= 1'b1;
      n = 0;
      do begin
        @(posedge clk_i);
        n = n + 1;
      end while (wb_ack_o !== 1'b1 && wb_err_o !== 1'b1 && n < 20);
      if (n >= 20) begin
        miscompares = miscompares + 1;
        finish_test;
      end
      q = wb_dat_o;
      er = wb_err_o;
      cyc <= 1'b0;
      wb_we_i <= 1'b0;
      @(posedge clk_i);
      #1;
    end
  endtask
  task wv(output integer c);
    begin
      c = 0;
      @(posedge clk_i);
      while (result_valid_o !== 1'b1 && c < 70000) begin
        @(posedge clk_i);
        c = c + 1;
      end
      if (c >= 70000) begin
        miscompares = miscompares + 1;
        finish_test;
      end
    end
  endtask
  // ****************
  // scenarios
  // ****************
  task s_regs;
    begin
      wb(8'h16, 1'b0, 32'h0);
      chk(q, 32'h00);
      wb(8'h19, 1'b0, 32'h0);
      chk(q, 32'h8000);
      wb(8'h16, 1'b1, 32'hA5);
      chk(aux_pos_input_sel_o, 32'hA);
      chk(aux_neg_input_sel_o, 32'h5);
      wb(8'h16, 1'b0, 32'h0);
      chk(q, 32'hA5);
      wb(8'h30, 1'b0, 32'h0);
      chk(er, 32'h1);
    end
  endtask
  task s_codes;
    begin
      for (i = 0; i < 8; i = i + 1) begin
        wb(8'h17, 1'b1, i << 5);
        chk(aux_gain_code_o, i);
        chk(ref_sel_onehot_o, 32'h1);
        chk(amp_bypass_o, i <= 2);
        chk(amp_gain_o * mod_gain_o, 1 << i);
        wb(8'h17, 1'b1, i << 2);
        chk(ref_sel_onehot_o, (i > 3) ? 32'h10 : (32'h1 << i));
        chk(aux_gain_code_o, 32'h0);
      end
      for (i = 0; i < 4; i = i + 1) begin
        wb(8'h1A, 1'b1, 32'h0C + i);
        chk(running_o, i < 2);
      end
    end
  endtask
  task s_rate(input [1:0] k, input integer a);
    integer c;
    begin
      wb(8'h17, 1'b1, {30'h0, k});
      wb(8'h1A, 1'b1, 32'h0C);
      wv(c);
      wv(c);
      chk(c + 1, a * MD);
    end
  endtask
  // a bypassed second stage would answer after three first-stage words
  task s_ten;
    integer n;
    begin
      wb(8'h17, 1'b1, 32'h0);
      wb(8'h1A, 1'b1, 32'h0C);
      n = 0;
      repeat (6 * 512 * MD) begin
        @(posedge clk_i);
        if (result_valid_o === 1'b1) n = n + 1;
      end
      chk(n, 0);
      // ten settled first-stage words after two warm-up words: the twelfth window of 512 bits, the sixth after the silent stretch
      wv(n);
      chk((n > 5 * 512 * MD) && (n <= 6 * 512 * MD + 2 * MD), 32'h1);
      chk(result_o[23:16], 32'h80);
    end
  endtask
  task s_dens;
    integer c;
    reg [23:0] lo;
    begin
      wb(8'h17, 1'b1, 32'h3);
      wb(8'h1A, 1'b1, 32'h0E);
      wb(8'h1A, 1'b1, 32'h0C);
      repeat (4) wv(c);
      lo = result_o;
      ones <= 1'b1;
      wb(8'h1A, 1'b1, 32'h0E);
      wb(8'h1A, 1'b1, 32'h0D);
      repeat (4) wv(c);
      q = result_o;
      wv(c);
      chk(result_o, q);
      chk($signed(q[23:0]) > $signed(lo), 32'h1);
      wb(8'h18, 1'b1, 32'h0010);
      wv(c);
      chk(result_o, 32'h7FFFEF);
      wb(8'h1B, 1'b0, 32'h0);
      chk(q, 32'h3);
      wb(8'h1C, 1'b0, 32'h0);
      chk(q, 32'h7FFFEF);
      wb(8'h1B, 1'b0, 32'h0);
      chk(q, 32'h1);
    end
  endtask
  initial begin
    forever #10 clk_i = ~clk_i;
  end
  initial begin
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    s_regs;
    s_codes;
    s_rate(2'h3, 64);
    s_rate(2'h2, 128);
    s_rate(2'h1, 512);
    s_ten;
    s_dens;
    finish_test;
  end
endmodule // tb
